// ---- verilog/asrc_top.sv ----
// Scan sequencer, range memory, trigger select and result readout
`timescale 1ns/1ps
`default_nettype none
`include "asrc_map.svh"

module asrc_top #(
  parameter bit REDUCED = 1'b0,
  parameter int CHANNELS = 16
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Host byte I/O port
  input wire logic [4:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Trigger sources
  input wire logic pacer_tick,
  input wire logic ext_trig_pin,
  // Analog front end
  output logic conv_start,
  output asrc_pkg::asrc_conv_req_t conv_req,
  output logic conv_busy,
  input wire logic conv_done,
  input wire logic [11:0] conv_data
);
  import asrc_pkg::*;

  // Host write strobes per address
  logic wr_low;
  logic wr_high;
  logic wr_scan;
  logic wr_ctrl;

  // Scan registers
  logic [3:0] start_q;
  logic [3:0] start_d;
  logic [3:0] stop_q;
  logic [3:0] stop_d;
  logic [3:0] cur_q;
  logic [3:0] cur_d;

  // Control register and trigger source
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] trig_sel;
  logic trig;

  // External trigger synchroniser and edge detect
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_rise;

  // Range memory
  logic [3:0] range_q [CHANNELS];
  logic [3:0] range_d [CHANNELS];
  logic [3:0] gain_mask;

  // Conversion tracking
  asrc_state_t state_q;
  asrc_state_t state_d;
  logic [3:0] tag_q;
  logic [3:0] tag_d;
  asrc_result_t res_q;
  asrc_result_t res_d;
  logic start_q_o;
  logic start_d_o;
  asrc_conv_req_t req_q;
  asrc_conv_req_t req_d;

  // Read data
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Address decode of host writes
  always_comb begin
    wr_low = io_wr && (io_addr == `ASRC_OFS_RESULT_LOW);
    wr_high = io_wr && (io_addr == `ASRC_OFS_RESULT_HIGH);
    wr_scan = io_wr && (io_addr == `ASRC_OFS_SCAN_LIMITS);
    wr_ctrl = io_wr && (io_addr == `ASRC_OFS_CONV_CTRL);
  end

  // Rising edge taken only after the second stage
  assign ext_rise = ext_s2_q && !ext_s3_q;

  // Pin crosses two flops before the edge detector looks at it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (ce) begin
      ext_s1_q <= ext_trig_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Trigger source select
  assign trig_sel = ctrl_q[`ASRC_TRIG_SEL_MSB:`ASRC_TRIG_SEL_LSB];

  // One trigger pulse from whichever source is armed
  always_comb begin
    unique case (trig_sel)
      `ASRC_TRIG_SOFT0,
      `ASRC_TRIG_SOFT1: trig = wr_low;
      `ASRC_TRIG_EXT: trig = ext_rise;
      `ASRC_TRIG_PACER: trig = pacer_tick;
    endcase
  end

  // Control register write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = io_wdata;
    end
  end

  // Scan sequencer; a scan write in the same cycle as a trigger wins,
  // so software always sees its new start channel take effect
  always_comb begin
    start_d = start_q;
    stop_d = stop_q;
    cur_d = cur_q;
    if (wr_scan) begin
      stop_d = io_wdata[`ASRC_SCAN_STOP_MSB:`ASRC_SCAN_STOP_LSB];
      start_d = io_wdata[`ASRC_SCAN_START_MSB:`ASRC_SCAN_START_LSB];
      cur_d = start_d;
    end else if (trig) begin
      if (cur_q == stop_q) begin
        cur_d = start_q;
      end else begin
        cur_d = cur_q + 4'h1;
      end
    end
  end

  // Reduced variant drops the two upper gain bits
  assign gain_mask = REDUCED ? `ASRC_REDUCED_GAIN_MASK
                             : `ASRC_FULL_GAIN_MASK;

  // Range memory update; start channel is the write pointer
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      range_d[i] = range_q[i];
    end
    if (wr_high) begin
      range_d[start_q] = io_wdata[`ASRC_GAIN_MSB:`ASRC_GAIN_LSB] & gain_mask;
    end
  end

  // Conversion launch and result capture
  always_comb begin
    state_d = state_q;
    tag_d = tag_q;
    res_d = res_q;
    start_d_o = 1'b0;
    req_d = req_q;
    if (trig) begin
      start_d_o = 1'b1;
      req_d.channel = cur_q;
      req_d.gain = range_q[cur_q] & gain_mask;
      tag_d = cur_q;
      state_d = ASRC_BUSY;
    end
    unique case (state_q)
      ASRC_IDLE: begin
      end
      ASRC_BUSY: begin
        // A fresh trigger keeps the block busy on the new conversion
        if (conv_done && !trig) begin
          state_d = ASRC_IDLE;
        end
      end
      default: state_d = ASRC_IDLE;
    endcase
    if (conv_done && (state_q == ASRC_BUSY)) begin
      res_d.data = conv_data;
      res_d.tag = tag_q;
    end
  end

  // Read mux, answered one cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (io_rd) begin
      unique case (io_addr)
        `ASRC_OFS_RESULT_LOW: rdata_d = {res_q.data[3:0], res_q.tag};
        `ASRC_OFS_RESULT_HIGH: rdata_d = res_q.data[11:4];
        `ASRC_OFS_SCAN_LIMITS: rdata_d = {4'h0, cur_q};
        `ASRC_OFS_CONV_CTRL: rdata_d = ctrl_q;
        default: rdata_d = `ASRC_RST_BYTE;
      endcase
    end
  end

  // Register stage for scan and control
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_q <= `ASRC_RST_CHAN;
      stop_q <= `ASRC_RST_CHAN;
      cur_q <= `ASRC_RST_CHAN;
      ctrl_q <= `ASRC_RST_CTRL;
    end else if (ce) begin
      start_q <= start_d;
      stop_q <= stop_d;
      cur_q <= cur_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Register stage for the range memory, cleared so every channel
  // starts at the widest bipolar code
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (srst) begin
        range_q[i] <= `ASRC_RST_GAIN;
      end else if (ce) begin
        range_q[i] <= range_d[i];
      end
    end
  end

  // Register stage for conversion tracking and readout
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ASRC_IDLE;
      tag_q <= `ASRC_RST_CHAN;
      res_q <= {`ASRC_RST_DATA, `ASRC_RST_CHAN};
      start_q_o <= 1'b0;
      req_q <= {`ASRC_RST_CHAN, `ASRC_RST_GAIN};
      rdata_q <= `ASRC_RST_BYTE;
    end else if (ce) begin
      state_q <= state_d;
      tag_q <= tag_d;
      res_q <= res_d;
      start_q_o <= start_d_o;
      req_q <= req_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign io_rdata = rdata_q;
  assign conv_start = start_q_o;
  assign conv_req = req_q;
  assign conv_busy = state_q[1]; // One-hot busy bit is itself a flop

endmodule
`default_nettype wire

// ---- shared/asrc_map.svh ----
// Register offsets, field positions and reset values of the scan/range control
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH

// Byte offsets on the host I/O port
`define ASRC_OFS_RESULT_LOW 5'h00
`define ASRC_OFS_RESULT_HIGH 5'h01
`define ASRC_OFS_SCAN_LIMITS 5'h02
`define ASRC_OFS_CONV_CTRL 5'h09

// Field positions
`define ASRC_SCAN_STOP_MSB 7
`define ASRC_SCAN_STOP_LSB 4
`define ASRC_SCAN_START_MSB 3
`define ASRC_SCAN_START_LSB 0
`define ASRC_GAIN_MSB 3
`define ASRC_GAIN_LSB 0
`define ASRC_TRIG_SEL_MSB 1
`define ASRC_TRIG_SEL_LSB 0

// Trigger source codes
`define ASRC_TRIG_SOFT0 2'h0
`define ASRC_TRIG_SOFT1 2'h1
`define ASRC_TRIG_EXT 2'h2
`define ASRC_TRIG_PACER 2'h3

// Reset values
`define ASRC_RST_CHAN 4'h0
`define ASRC_RST_GAIN 4'h0
`define ASRC_RST_CTRL 8'h00
`define ASRC_RST_DATA 12'h000
`define ASRC_RST_BYTE 8'h00

// Gain bits kept on the reduced and full variants
`define ASRC_REDUCED_GAIN_MASK 4'h3
`define ASRC_FULL_GAIN_MASK 4'hF

`endif

// ---- shared/asrc_pkg.sv ----
// Types shared by the scan/range control block
package asrc_pkg;

  // Request handed to the analog front end
  typedef struct packed {
    logic [3:0] channel;
    logic [3:0] gain;
  } asrc_conv_req_t;

  // Finished result with its source channel
  typedef struct packed {
    logic [11:0] data;
    logic [3:0] tag;
  } asrc_result_t;

  // Conversion tracking state
  typedef enum logic [1:0] {
    ASRC_IDLE = 2'b01,
    ASRC_BUSY = 2'b10
  } asrc_state_t;

endpackage

// ---- verification/asrc_properties.sv ----
// Port-level checker for the scan/range control block
`timescale 1ns/1ps
`default_nettype none
module asrc_props #(parameter bit REDUCED = 1'b0) (
  // Clock, reset, host port
  input wire logic ref_clk, srst, ce, io_rd, io_wr, pacer_tick, ext_trig_pin,
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_wdata, io_rdata,
  // Front end
  input wire asrc_pkg::asrc_conv_req_t conv_req,
  input wire logic conv_start, conv_busy, conv_done,
  input wire logic [11:0] conv_data);
  import asrc_pkg::*;
  localparam logic [3:0] GM = REDUCED ? 4'h3 : 4'hF;
  logic [1:0] sel_q, sel_d;
  logic sw, wr1, wr2, rd0, rd1, rd2, fin;
  // Shadow of the trigger select, so checks know which source counts
  always_comb begin
    sel_d = sel_q;
    if (ce && io_wr && io_addr == 5'h09) sel_d = io_wdata[1:0];
  end
  always_ff @(posedge ref_clk) sel_q <= srst ? 2'h0 : sel_d;
  // Decoded host strobes
  assign sw = ce && io_wr && io_addr == 5'h00 && !sel_q[1];
  assign wr1 = ce && io_wr && io_addr == 5'h01;
  assign wr2 = ce && io_wr && io_addr == 5'h02;
  assign rd0 = ce && io_rd && io_addr == 5'h00;
  assign rd1 = ce && io_rd && io_addr == 5'h01;
  assign rd2 = ce && io_rd && io_addr == 5'h02;
  assign fin = ce && conv_busy && conv_done;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_soft_start: assert property (sw |=> conv_start)
    else $error("no start after software write");
  a_pacer_start: assert property (ce && pacer_tick && sel_q == 2'h3 |=> conv_start)
    else $error("no start after pacer tick");
  a_start_cause: assert property (
    conv_start && $past(sel_q) != 2'h2 |-> $past(sw || ce && pacer_tick && sel_q == 2'h3))
    else $error("start from an unselected source");
  a_scan_load: assert property (
    wr2 ##2 rd2 |=> io_rdata == {4'h0, $past(io_wdata[3:0], 3)}) else $error("scan load");
  a_req_chan: assert property (
    wr2 ##2 sw |=> conv_req.channel == $past(io_wdata[3:0], 3)) else $error("request channel");
  a_range_use: assert property (
    wr2 ##2 wr1 ##2 sw |=> conv_req.gain == ($past(io_wdata[3:0], 3) & GM))
    else $error("range entry not applied");
  a_res_low: assert property (
    fin ##1 rd0 |=> io_rdata == {$past(conv_data[3:0], 2), $past(conv_req.channel, 2)})
    else $error("low result byte");
  a_res_high: assert property (fin ##1 rd1 |=> io_rdata == $past(conv_data[11:4], 2))
    else $error("high result byte");
endmodule
bind asrc_top asrc_props #(.REDUCED(REDUCED)) u_props (.*);
`default_nettype wire

// ---- verification/asrc_fe_model.sv ----
// Behavioural analog front end answering conversion starts
`timescale 1ns/1ps
`default_nettype none
module asrc_fe_model (
  // Clock, reset, request
  input wire logic ref_clk, srst, conv_start, slow,
  input wire asrc_pkg::asrc_conv_req_t conv_req,
  // Result
  output logic conv_done,
  output logic [11:0] conv_data);
  import asrc_pkg::*;
  logic [3:0] cnt = 4'h0;
  logic [11:0] res = 12'h000;
  // A new start restarts the count, as a real converter would
  always @(posedge ref_clk) begin
    if (srst) cnt <= 4'h0;
    else if (conv_start) cnt <= slow ? 4'hA : 4'h1;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    res <= {conv_req, ~conv_req.gain};
  end
  // Data is only good with done; scrambled otherwise so stale values never match
  assign conv_done = cnt == 4'h1;
  assign conv_data = conv_done ? res : ~res;
endmodule
`default_nettype wire

// ---- verification/asrc_top_bench.sv ----
// Self-checking bench for the scan/range control block
`timescale 1ns/1ps
`default_nettype none
module asrc_top_bench;
  import asrc_pkg::*;
  localparam bit RED = 1'b0;
  logic ref_clk = 1'b0, srst = 1'b1, io_rd = 1'b0, io_wr = 1'b0, pacer_tick = 1'b0, slow = 1'b0;
  logic ce = 1'b1, ext_trig_pin = 1'b0;
  logic [4:0] io_addr = 5'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, v;
  logic conv_start, conv_busy, conv_done;
  logic [11:0] conv_data;
  asrc_conv_req_t conv_req;
  logic [3:0] gn [16];
  int failures = 0, n_checks = 0, s, e, c;
  asrc_top #(.REDUCED(RED)) DUT (.*);
  asrc_fe_model u_fe (.*);
  initial forever #2 ref_clk = ~ref_clk;
  // Gain kept by the range memory for a written byte
  function automatic logic [3:0] gm(input logic [7:0] d);
    return d[3:0] & (RED ? 4'h3 : 4'hF);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Host accesses: one strobe cycle, then one idle cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    #1 chk(io_rdata, exp);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1;
      if (conv_done === 1'b1) return;
    end
    failures++;
    $display("MISMATCH %0t no conversion done", $time);
    tally_and_finish();
  endtask
  initial begin
    void'($urandom(32'h41C6));
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    // Scan limits: full span first, then random start/stop pairs
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 0 : $urandom % 16;
      e = (k == 0) ? 15 : s + $urandom % (16 - s);
      wr(5'h02, {e[3:0], s[3:0]});
      c = s;
      for (int t = 0; t < 18; t++) begin
        rd(5'h02, 8'(c));
        wr(5'h00, 8'($urandom));
        chk(conv_req.channel, 8'(c));
        c = (c == e) ? s : c + 1;
      end
    end
    // Fill every range entry, upper nibble junk, trigger right after
    for (int ch = 0; ch < 16; ch++) begin
      v = (ch == 0) ? 8'hFF : 8'($urandom);
      gn[ch] = gm(v);
      wr(5'h02, 8'(ch));
      wr(5'h01, v);
      wr(5'h00, 8'h00);
      chk(conv_req.gain, gn[ch]);
    end
    // Ranging leaves the scan unknown, so set it again and sweep
    wr(5'h02, 8'hF0);
    for (int ch = 0; ch < 16; ch++) begin
      slow <= 1'($urandom);
      wr(5'h00, 8'hA5);
      chk(conv_req.gain, gn[ch]);
      chk(8'(conv_busy), 8'h01);
      wait_done();
      if (ch % 2 == 1) rd(5'h01, {4'(ch), gn[ch]});
      rd(5'h00, {~gn[ch], 4'(ch)});
      rd(5'h01, {4'(ch), gn[ch]});
    end
    // Pacer mode ignores software writes but follows ticks
    wr(5'h09, 8'h03);
    wr(5'h02, 8'h52);
    wr(5'h00, 8'h00);
    rd(5'h02, 8'h02);
    @(posedge ref_clk) pacer_tick <= 1'b1;
    @(posedge ref_clk) pacer_tick <= 1'b0;
    rd(5'h02, 8'h03);
    // Select code 1 is software triggering too
    wr(5'h09, 8'h01);
    wr(5'h00, 8'h00);
    rd(5'h02, 8'h04);
    // External mode: one pin rise steps the scan once, writes do not
    wr(5'h09, 8'h02);
    wr(5'h00, 8'h00);
    @(posedge ref_clk) ext_trig_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ext_trig_pin <= 1'b0;
    rd(5'h02, 8'h05);
    // Clock enable low must swallow a scan write
    ce <= 1'b0;
    wr(5'h02, 8'h11);
    ce <= 1'b1;
    rd(5'h02, 8'h05);
    tally_and_finish();
  end
endmodule
`default_nettype wire
